// ### bench/interrupt_enable_priority_regs_test.sv
// Self-checking bench for the enable four and priority zero register slice.
// Assumes the package constants and the one-wait-cycle Avalon-MM slave answer.
`timescale 1ns/100ps
module interrupt_enable_priority_regs_test;
  import irq_regs_pkg::*;
  typedef struct {logic [ADDR_W-1:0] a; logic [15:0] d; logic [3:0] be; logic [15:0] e;} row_t;
  logic                    clk_i;
  logic                    rst_n_i;
  logic [ADDR_W-1:0]       address;
  logic                    rd;
  logic                    wr;
  logic [DATA_W-1:0]       wdata;
  logic [3:0]              be;
  logic [DATA_W-1:0]       rdata;
  logic                    wq;
  logic [NUM_EN_SRC-1:0]   en_req;
  logic [NUM_PRIO_SRC-1:0] pr_req;
  logic [NUM_EN_SRC-1:0]   en_fwd;
  logic [NUM_PRIO_SRC-1:0] pr_fwd;
  logic [11:0]             level;
  logic [31:0]             q;
  int                      fails;
  int                      checked;
  int                      pos[5] = '{1, 2, 3, 8, 13};
  row_t rows[7] = '{
    '{4'h0, 16'hFFFF, 4'hF, 16'h210E}, '{4'h0, 16'h0000, 4'hF, 16'h0000},
    '{4'h0, 16'hDEF1, 4'hF, 16'h0000}, '{4'h4, 16'hFFFF, 4'hF, 16'h7777},
    '{4'h4, 16'h0000, 4'h1, 16'h7700}, '{4'h4, 16'h1234, 4'hF, 16'h1234},
    '{4'hC, 16'hFFFF, 4'hF, 16'h0000}};

  interrupt_enable_priority_regs DUT (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(address), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wq), .en_req_i(en_req),
    .pr_req_i(pr_req), .en_fwd_o(en_fwd), .pr_fwd_o(pr_fwd), .pr_level_o(level));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      fails++;
    end
  endtask : chk

  // Waitrequest and read data are registered, so just after a rising edge they still
  // show what the slave presented at that edge; the request is released there.
  task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d,
                     input logic [3:0] b, output logic [31:0] r);
    @(posedge clk_i);
    rd      <= ~w;
    wr      <= w;
    address <= a;
    wdata   <= {16'h0000, d};
    be      <= b;
    do begin
      @(posedge clk_i);
    end while (wq !== 1'b0);
    r = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : acc

  task automatic settle();
    @(posedge clk_i);
    @(negedge clk_i);
  endtask : settle

  task automatic finish_test();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    #150000;
    fails++;
    finish_test();
  end

  initial begin
    rst_n_i = 1'b0;
    {rd, wr, address, wdata, be, en_req, pr_req} = '0;
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    settle();
    chk({20'h0, level}, 32'h0000_0924);
    acc(1'b0, OFS_ENABLE_FOUR, 16'h0, 4'hF, q);
    chk(q, 32'h0000_0000);
    acc(1'b0, OFS_PRIORITY_ZERO, 16'h0, 4'hF, q);
    chk(q, 32'h0000_4444);
    foreach (rows[i]) begin
      acc(1'b1, rows[i].a, rows[i].d, rows[i].be, q);
      acc(1'b0, rows[i].a, 16'h0, 4'hF, q);
      chk(q, {16'h0, rows[i].e});
    end
    en_req <= 5'h1F;
    pr_req <= 4'hF;
    for (int i = 0; i < 5; i++) begin
      acc(1'b1, OFS_ENABLE_FOUR, 16'h0001 << pos[i], 4'hF, q);
      settle();
      chk({27'h0, en_fwd}, 32'h1 << i);
    end
    acc(1'b1, OFS_ENABLE_FOUR, 16'h0000, 4'hF, q);
    settle();
    chk({27'h0, en_fwd}, 32'h0);
    // Timer and capture at code zero, compare and external at the top code.
    acc(1'b1, OFS_PRIORITY_ZERO, 16'h0707, 4'hF, q);
    settle();
    chk({28'h0, pr_fwd}, 32'h5);
    chk({20'h0, level}, 32'h1C7);
    acc(1'b0, OFS_PENDING_VIEW, 16'h0, 4'hF, q);
    chk(q, 32'h0000_00A0);
    // A second reset in mid-run must restore both registers.
    acc(1'b1, OFS_ENABLE_FOUR, 16'h210E, 4'hF, q);
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    settle();
    chk({27'h0, en_fwd}, 32'h0);
    acc(1'b0, OFS_ENABLE_FOUR, 16'h0, 4'hF, q);
    chk(q, 32'h0000_0000);
    acc(1'b0, OFS_PRIORITY_ZERO, 16'h0, 4'hF, q);
    chk(q, 32'h0000_4444);
    finish_test();
  end
endmodule : interrupt_enable_priority_regs_test

// ### rtl/interrupt_enable_priority_regs.sv
// Enable register four and priority register zero behind an Avalon-MM slave.
// Assumes a single clock, synchronous request inputs and a well-behaved master.
`timescale 1ns/100ps
module interrupt_enable_priority_regs
  import irq_regs_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_n_i,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0]       avs_address_i,
  input  wire logic                    avs_read_i,
  input  wire logic                    avs_write_i,
  input  wire logic [DATA_W-1:0]       avs_writedata_i,
  input  wire logic [3:0]              avs_byteenable_i,
  output logic      [DATA_W-1:0]       avs_readdata_o,
  output logic                         avs_waitrequest_o,
  // Source requests, bit order serial_a, serial_b, checksum, voltage, charge
  input  wire logic [NUM_EN_SRC-1:0]   en_req_i,
  // Source requests, bit order ext_irq_zero, capture, compare, timer
  input  wire logic [NUM_PRIO_SRC-1:0] pr_req_i,
  // Forwarded requests toward arbitration
  output logic      [NUM_EN_SRC-1:0]   en_fwd_o,
  output logic      [NUM_PRIO_SRC-1:0] pr_fwd_o,
  output logic      [NUM_PRIO_SRC*PRIO_W-1:0] pr_level_o
);
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK  = 2'b01
  } bus_state_t;

  bus_state_t         state;
  bus_state_t         next_state;
  logic [REG_W-1:0]   enable_four;
  logic [REG_W-1:0]   priority_zero;
  logic [REG_W-1:0]   next_enable_four;
  logic [REG_W-1:0]   next_priority_zero;
  logic [DATA_W-1:0]  next_readdata;
  logic [REG_W-1:0]   lane_mask;
  logic [REG_W-1:0]   pending_view;

  irq_src_if #(.N_EN(NUM_EN_SRC), .N_PR(NUM_PRIO_SRC), .PW(PRIO_W)) src ();

  irq_forward_gate u_gate (
    .src (src.gate)
  );

  function automatic logic [PRIO_W-1:0] field_of(input logic [REG_W-1:0] r,
                                                 input int unsigned pos);
    field_of = r[pos +: PRIO_W];
  endfunction : field_of

  // Every access takes two cycles: the request is seen, then acknowledged.
  // The one-cycle stall keeps read data registered and the outputs glitch free.
  // Read data are captured at the edge that sees the request, so they stand at the answer edge.
  wire access    = avs_read_i | avs_write_i;
  wire take      = (state == BUS_ACK);
  wire seen      = (state == BUS_IDLE) & access;
  wire answer_rd = seen & avs_read_i;
  wire sel_en    = (avs_address_i == OFS_ENABLE_FOUR);
  wire sel_pr    = (avs_address_i == OFS_PRIORITY_ZERO);
  wire sel_pend  = (avs_address_i == OFS_PENDING_VIEW);
  wire do_write  = take & avs_write_i;

  assign lane_mask = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

  always_comb begin
    unique case (state)
      BUS_IDLE: next_state = access ? BUS_ACK : BUS_IDLE;
      BUS_ACK:  next_state = BUS_IDLE;
      default:  next_state = BUS_IDLE;
    endcase
  end

  // Unimplemented bits are masked so they never store a one.
  assign next_enable_four = (do_write && sel_en) ?
    (((avs_writedata_i[REG_W-1:0] & lane_mask) | (enable_four & ~lane_mask))
     & ENABLE_MASK) : enable_four;
  assign next_priority_zero = (do_write && sel_pr) ?
    (((avs_writedata_i[REG_W-1:0] & lane_mask) | (priority_zero & ~lane_mask))
     & PRIORITY_MASK) : priority_zero;

  assign pending_view = {{(REG_W-NUM_EN_SRC-NUM_PRIO_SRC){1'b0}}, src.pr_fwd, src.en_fwd};

  assign next_readdata = !answer_rd ? UNMAPPED_READ :
    sel_en   ? {{(DATA_W-REG_W){1'b0}}, enable_four}   :
    sel_pr   ? {{(DATA_W-REG_W){1'b0}}, priority_zero} :
    sel_pend ? {{(DATA_W-REG_W){1'b0}}, pending_view}  : UNMAPPED_READ;

  // Map register bits to the per-source controls.
  assign src.en = {enable_four[BIT_CHARGE_TIME], enable_four[BIT_VOLTAGE_DETECT],
                   enable_four[BIT_CHECKSUM_GEN], enable_four[BIT_SERIAL_B_ERR],
                   enable_four[BIT_SERIAL_A_ERR]};
  assign src.prio[3] = field_of(priority_zero, POS_TIMER_ONE);
  assign src.prio[2] = field_of(priority_zero, POS_COMPARE_ONE);
  assign src.prio[1] = field_of(priority_zero, POS_CAPTURE_ONE);
  assign src.prio[0] = field_of(priority_zero, POS_EXT_IRQ_ZERO);
  assign src.en_req = en_req_i;
  assign src.pr_req = pr_req_i;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state         <= BUS_IDLE;
      enable_four   <= ENABLE_RESET;
      priority_zero <= PRIORITY_RESET;
    end else begin
      state         <= next_state;
      enable_four   <= next_enable_four;
      priority_zero <= next_priority_zero;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_readdata_o    <= UNMAPPED_READ;
      avs_waitrequest_o <= 1'b1;
      en_fwd_o          <= '0;
      pr_fwd_o          <= '0;
      pr_level_o        <= '0;
    end else begin
      avs_readdata_o    <= next_readdata;
      avs_waitrequest_o <= !(next_state == BUS_ACK);
      en_fwd_o          <= src.en_fwd;
      pr_fwd_o          <= src.pr_fwd;
      pr_level_o        <= src.prio;
    end
  end

  // Assertions.
  property p_charge_gate;
    @(posedge clk_i) disable iff (!rst_n_i)
      en_req_i[4] && !enable_four[BIT_CHARGE_TIME] |=> !en_fwd_o[4];
  endproperty
  a_charge_gate: assert property (p_charge_gate) else $error("charge request passed");

  property p_voltage_pass;
    @(posedge clk_i) disable iff (!rst_n_i)
      en_req_i[3] && enable_four[BIT_VOLTAGE_DETECT] |=> en_fwd_o[3];
  endproperty
  a_voltage_pass: assert property (p_voltage_pass) else $error("voltage request lost");

  property p_checksum_gate;
    @(posedge clk_i) disable iff (!rst_n_i)
      ##1 en_fwd_o[2] |-> $past(enable_four[BIT_CHECKSUM_GEN]) && $past(en_req_i[2]);
  endproperty
  a_checksum_gate: assert property (p_checksum_gate) else $error("checksum gate bad");

  property p_serial_b;
    @(posedge clk_i) disable iff (!rst_n_i)
      en_req_i[1] |=> en_fwd_o[1] == $past(enable_four[BIT_SERIAL_B_ERR]);
  endproperty
  a_serial_b: assert property (p_serial_b) else $error("serial b gate bad");

  property p_serial_a;
    @(posedge clk_i) disable iff (!rst_n_i)
      en_req_i[0] |=> en_fwd_o[0] == $past(enable_four[BIT_SERIAL_A_ERR]);
  endproperty
  a_serial_a: assert property (p_serial_a) else $error("serial a gate bad");

  property p_unimpl_zero;
    @(posedge clk_i) disable iff (!rst_n_i)
      (enable_four & ~ENABLE_MASK) == '0 && (priority_zero & ~PRIORITY_MASK) == '0;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bit set");

  sequence s_full_write_en;
    do_write && sel_en && avs_byteenable_i == 4'hF;
  endsequence
  property p_write_en;
    @(posedge clk_i) disable iff (!rst_n_i)
      s_full_write_en |=> enable_four == ($past(avs_writedata_i[REG_W-1:0]) & ENABLE_MASK);
  endproperty
  a_write_en: assert property (p_write_en) else $error("enable write lost");

  sequence s_read_pr;
    answer_rd && sel_pr;
  endsequence
  property p_read_pr;
    @(posedge clk_i) disable iff (!rst_n_i)
      s_read_pr |=> avs_readdata_o[REG_W-1:0] == $past(priority_zero) && !avs_waitrequest_o;
  endproperty
  a_read_pr: assert property (p_read_pr) else $error("priority read wrong");

  property p_zero_prio_blocks;
    @(posedge clk_i) disable iff (!rst_n_i)
      field_of(priority_zero, POS_TIMER_ONE) == PRIO_OFF |=> !pr_fwd_o[3];
  endproperty
  a_zero_prio_blocks: assert property (p_zero_prio_blocks)
    else $error("disabled source passed");

  property p_fwd_cause;
    @(posedge clk_i) disable iff (!rst_n_i)
      ##1 pr_fwd_o[1] |-> $past(pr_req_i[1]) && $past(priority_zero[6:4]) != PRIO_OFF;
  endproperty
  a_fwd_cause: assert property (p_fwd_cause) else $error("capture forwarded wrongly");

  sequence s_req_seen;
    seen;
  endsequence
  sequence s_answer_cycle;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  property p_answer_next;
    @(posedge clk_i) disable iff (!rst_n_i)
      s_req_seen |=> s_answer_cycle;
  endproperty
  a_answer_next: assert property (p_answer_next)
    else $error("answer cycle wrong");

  property p_wait_only_answer;
    @(posedge clk_i) disable iff (!rst_n_i)
      !avs_waitrequest_o |-> $past(seen);
  endproperty
  a_wait_only_answer: assert property (p_wait_only_answer)
    else $error("waitrequest low without request");

  property p_readdata_idle;
    @(posedge clk_i) disable iff (!rst_n_i)
      !$past(answer_rd) |-> avs_readdata_o == UNMAPPED_READ;
  endproperty
  a_readdata_idle: assert property (p_readdata_idle)
    else $error("read data outside answer");

  property p_read_en;
    @(posedge clk_i) disable iff (!rst_n_i)
      answer_rd && sel_en |=> avs_readdata_o == {16'h0000, $past(enable_four)};
  endproperty
  a_read_en: assert property (p_read_en)
    else $error("enable read wrong");

  property p_read_unmapped;
    @(posedge clk_i) disable iff (!rst_n_i)
      answer_rd && !sel_en && !sel_pr && !sel_pend |=> avs_readdata_o == UNMAPPED_READ;
  endproperty
  a_read_unmapped: assert property (p_read_unmapped)
    else $error("unmapped read not zero");

  sequence s_full_write_pr;
    do_write && sel_pr && avs_byteenable_i == 4'hF;
  endsequence
  property p_write_pr;
    @(posedge clk_i) disable iff (!rst_n_i)
      s_full_write_pr |=> priority_zero == ($past(avs_writedata_i[REG_W-1:0]) & PRIORITY_MASK);
  endproperty
  a_write_pr: assert property (p_write_pr)
    else $error("priority write lost");

  property p_hold_en;
    @(posedge clk_i) disable iff (!rst_n_i)
      !(do_write && sel_en) |=> $stable(enable_four);
  endproperty
  a_hold_en: assert property (p_hold_en)
    else $error("enable changed without write");

  property p_hold_pr;
    @(posedge clk_i) disable iff (!rst_n_i)
      !(do_write && sel_pr) |=> $stable(priority_zero);
  endproperty
  a_hold_pr: assert property (p_hold_pr)
    else $error("priority changed without write");

  property p_level_timer;
    @(posedge clk_i) disable iff (!rst_n_i)
      1'b1 |=> pr_level_o[3*PRIO_W +: PRIO_W] == $past(priority_zero[POS_TIMER_ONE +: PRIO_W]);
  endproperty
  a_level_timer: assert property (p_level_timer)
    else $error("timer level wrong");

  property p_level_compare;
    @(posedge clk_i) disable iff (!rst_n_i)
      1'b1 |=> pr_level_o[2*PRIO_W +: PRIO_W] == $past(priority_zero[POS_COMPARE_ONE +: PRIO_W]);
  endproperty
  a_level_compare: assert property (p_level_compare)
    else $error("compare level wrong");

  property p_level_capture;
    @(posedge clk_i) disable iff (!rst_n_i)
      1'b1 |=> pr_level_o[PRIO_W +: PRIO_W] == $past(priority_zero[POS_CAPTURE_ONE +: PRIO_W]);
  endproperty
  a_level_capture: assert property (p_level_capture)
    else $error("capture level wrong");

  property p_level_ext;
    @(posedge clk_i) disable iff (!rst_n_i)
      1'b1 |=> pr_level_o[0 +: PRIO_W] == $past(priority_zero[POS_EXT_IRQ_ZERO +: PRIO_W]);
  endproperty
  a_level_ext: assert property (p_level_ext)
    else $error("external level wrong");

  property p_pr_pass;
    @(posedge clk_i) disable iff (!rst_n_i)
      pr_req_i[0] && field_of(priority_zero, POS_EXT_IRQ_ZERO) != PRIO_OFF |=> pr_fwd_o[0];
  endproperty
  a_pr_pass: assert property (p_pr_pass)
    else $error("external request lost");

  property p_en_cause;
    @(posedge clk_i) disable iff (!rst_n_i)
      ##1 en_fwd_o[4] |-> $past(en_req_i[4]) && $past(enable_four[BIT_CHARGE_TIME]);
  endproperty
  a_en_cause: assert property (p_en_cause)
    else $error("charge forwarded wrongly");

  property p_checksum_pass;
    @(posedge clk_i) disable iff (!rst_n_i)
      en_req_i[2] && enable_four[BIT_CHECKSUM_GEN] |=> en_fwd_o[2];
  endproperty
  a_checksum_pass: assert property (p_checksum_pass)
    else $error("checksum request lost");

  property p_prio_top;
    @(posedge clk_i) disable iff (!rst_n_i)
      pr_req_i[2] && field_of(priority_zero, POS_COMPARE_ONE) == 3'h7 |=>
        pr_fwd_o[2] && pr_level_o[2*PRIO_W +: PRIO_W] == 3'h7;
  endproperty
  a_prio_top: assert property (p_prio_top)
    else $error("top priority not passed");
endmodule : interrupt_enable_priority_regs

// ### rtl/irq_forward_gate.sv
// Combinational gate that passes a pending request only when it is allowed.
// Assumes requests are levels synchronous to the register file's clock.
`timescale 1ns/100ps
module irq_forward_gate
  import irq_regs_pkg::*;
(
  // Source controls and requests
  irq_src_if.gate src
);
  // Enable-gated sources carry no priority field in this slice.
  assign src.en_fwd = src.en_req & src.en;

  // Priority-gated sources: code zero disables, any other code passes.
  genvar g;
  generate
    for (g = 0; g < NUM_PRIO_SRC; g++) begin : g_prio
      assign src.pr_fwd[g] = src.pr_req[g] & (src.prio[g] != PRIO_OFF);
    end
  endgenerate
endmodule : irq_forward_gate

// ### rtl/irq_regs_pkg.sv
// Constants for the interrupt enable and priority register slice.
// Assumes a 16-bit register view placed in the low bits of a 32-bit Avalon-MM word.
package irq_regs_pkg;
  localparam int unsigned ADDR_W           = 4;
  localparam int unsigned DATA_W           = 32;
  localparam int unsigned REG_W            = 16;
  localparam int unsigned PRIO_W           = 3;
  localparam int unsigned NUM_EN_SRC       = 5;
  localparam int unsigned NUM_PRIO_SRC     = 4;

  // Byte offsets of the registers.
  localparam logic [ADDR_W-1:0] OFS_ENABLE_FOUR  = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_PRIORITY_ZERO = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_PENDING_VIEW = 4'h8;

  // Enable register field positions.
  localparam int unsigned BIT_CHARGE_TIME    = 13;
  localparam int unsigned BIT_VOLTAGE_DETECT = 8;
  localparam int unsigned BIT_CHECKSUM_GEN   = 3;
  localparam int unsigned BIT_SERIAL_B_ERR   = 2;
  localparam int unsigned BIT_SERIAL_A_ERR   = 1;
  localparam logic [REG_W-1:0] ENABLE_MASK   = 16'h210E;
  localparam logic [REG_W-1:0] ENABLE_RESET  = 16'h0000;

  // Priority register field positions (lsb of each 3-bit field).
  localparam int unsigned POS_TIMER_ONE      = 12;
  localparam int unsigned POS_COMPARE_ONE    = 8;
  localparam int unsigned POS_CAPTURE_ONE    = 4;
  localparam int unsigned POS_EXT_IRQ_ZERO   = 0;
  localparam logic [REG_W-1:0] PRIORITY_MASK = 16'h7777;
  localparam logic [PRIO_W-1:0] PRIO_RESET   = 3'h4;
  localparam logic [PRIO_W-1:0] PRIO_OFF     = 3'h0;
  localparam logic [REG_W-1:0] PRIORITY_RESET = 16'h4444;

  localparam logic [DATA_W-1:0] UNMAPPED_READ = 32'h0000_0000;
endpackage : irq_regs_pkg

// ### rtl/irq_src_if.sv
// Carries per-source enable and priority between the register file and the gate.
// Assumes both ends share the register file's clock.
`timescale 1ns/100ps
interface irq_src_if #(
  parameter int unsigned N_EN = 5,
  parameter int unsigned N_PR = 4,
  parameter int unsigned PW   = 3
);
  logic [N_EN-1:0]         en;
  logic [N_EN-1:0]         en_req;
  logic [N_EN-1:0]         en_fwd;
  logic [N_PR-1:0][PW-1:0] prio;
  logic [N_PR-1:0]         pr_req;
  logic [N_PR-1:0]         pr_fwd;

  modport regs (output en, output prio, output en_req, output pr_req,
                input en_fwd, input pr_fwd);
  modport gate (input en, input prio, input en_req, input pr_req,
                output en_fwd, output pr_fwd);
endinterface : irq_src_if
